/* File: cgs_axil.sv */
`timescale 1ns/1ps
// AXI4-Lite slave front end for 8-bit registers in the low byte lane
module cgs_axil (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire cgs_pkg::cgs_axi_req_t axi_req,
  output cgs_pkg::cgs_axi_rsp_t axi_rsp,
  // register file side
  output cgs_pkg::cgs_regwr_t reg_wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);

  typedef struct packed {
    logic aw_full;
    logic [7:0] awaddr;
    logic w_full;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cgs_axil_st_t;

  cgs_axil_st_t s_q;
  cgs_axil_st_t s_d;
  logic awready;
  logic wready;
  logic arready;

  // address and data are held separately so they may arrive in either order
  assign awready = !s_q.aw_full && !s_q.bvalid;
  assign wready = !s_q.w_full && !s_q.bvalid;
  assign arready = !s_q.rvalid;
  assign rd_addr = axi_req.araddr;

  // write path, then read path; the read data is captured at the handshake
  always_comb begin
    s_d = s_q;
    reg_wr = '0;
    if (axi_req.awvalid && awready) begin
      s_d.aw_full = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && wready) begin
      s_d.w_full = 1'b1;
      s_d.wdata = axi_req.wdata[7:0];
      s_d.wstrb0 = axi_req.wstrb[0];
    end
    if (s_q.aw_full && s_q.w_full) begin
      reg_wr.en = s_q.wstrb0 && cgs_pkg::cgs_mapped(s_q.awaddr);
      reg_wr.addr = s_q.awaddr;
      reg_wr.data = s_q.wdata;
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = cgs_pkg::cgs_mapped(s_q.awaddr) ? cgs_pkg::RESP_OKAY : cgs_pkg::RESP_SLVERR;
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (axi_req.arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = {24'h000000, rd_data};
      s_d.rresp = cgs_pkg::cgs_mapped(axi_req.araddr) ? cgs_pkg::RESP_OKAY : cgs_pkg::RESP_SLVERR;
    end
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // bus answer
  always_comb begin
    axi_rsp.awready = awready;
    axi_rsp.wready = wready;
    axi_rsp.bresp = s_q.bresp;
    axi_rsp.bvalid = s_q.bvalid;
    axi_rsp.arready = arready;
    axi_rsp.rdata = s_q.rdata;
    axi_rsp.rresp = s_q.rresp;
    axi_rsp.rvalid = s_q.rvalid;
  end

endmodule

/* File: cgs_pkg.sv */
package cgs_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TRIM = 8'h08;
  localparam logic [7:0] OFF_CFG = 8'h0C;

  // status field positions
  localparam int STAT_LOST = 7;
  localparam int STAT_LOCK = 6;
  localparam int STAT_REFSRC = 4;
  localparam int STAT_OSEL_LO = 2;

  // control field positions: [7:6] output select, [5:3] divider, [2] ref source
  localparam int CTRL_OSEL_LO = 6;
  localparam int CTRL_DIV_LO = 3;
  localparam int CTRL_REFSEL = 2;

  // config field positions
  localparam int CFG_IRQ_EN = 7;
  localparam int CFG_LOW_POWER = 0;

  // reset values: engaged on the internal reference, loop running
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [7:0] CFG_RST = 8'h00;

  // consecutive in-band cycles before the loop counts as locked
  localparam int LOCK_ACQ_CYC = 16;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OSEL_LOOP = 2'b00,
    OSEL_INT = 2'b01,
    OSEL_EXT = 2'b10,
    OSEL_RSVD = 2'b11
  } cgs_osel_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } cgs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } cgs_axi_rsp_t;

  // one register write, handed from the bus slave to the register file
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } cgs_regwr_t;

  function automatic logic cgs_mapped(logic [7:0] a);
    return (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_TRIM) || (a == OFF_CFG);
  endfunction

endpackage

/* File: cgs_status_top.sv */
`timescale 1ns/1ps
module cgs_status_top #(
  parameter int LOCK_ACQ_CYCLES = cgs_pkg::LOCK_ACQ_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire cgs_pkg::cgs_axi_req_t axi_req,
  output cgs_pkg::cgs_axi_rsp_t axi_rsp,
  // loop and reference monitors (asynchronous pins)
  input wire logic loop_in_band,
  input wire logic ext_ref_ok,
  // system mode, same clock
  input wire logic stop_entry,
  // outputs
  output logic loop_enable,
  output logic irq
);

  localparam int ACQ_W = $clog2(LOCK_ACQ_CYCLES + 1);
  localparam logic [ACQ_W-1:0] ACQ_LAST = ACQ_W'(LOCK_ACQ_CYCLES - 1);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] trim;
    logic [7:0] cfg;
    cgs_pkg::cgs_osel_t osel_acc;
    logic locked;
    logic lost;
    logic [ACQ_W-1:0] acq_cnt;
  } cgs_top_st_t;

  cgs_top_st_t s_q;
  cgs_top_st_t s_d;
  cgs_pkg::cgs_regwr_t reg_wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic band_s;
  logic ext_ok_s;
  logic ref_status;
  logic [1:0] osel_status_raw;
  cgs_pkg::cgs_osel_t osel_status;
  cgs_pkg::cgs_osel_t osel_req;
  logic loop_on;
  logic trim_sens;
  logic wr_ctrl;
  logic wr_trim;
  logic wr_status;
  logic cfg_chg;
  logic lose_evt;
  logic lost_clr;
  logic [7:0] status_val;

  // an output clock can be taken only if its source is running
  function automatic logic osel_avail(cgs_pkg::cgs_osel_t s, logic ext_ok);
    logic ok;
    ok = 1'b0;
    unique case (s)
      cgs_pkg::OSEL_LOOP: ok = 1'b1;
      cgs_pkg::OSEL_INT: ok = 1'b1;
      cgs_pkg::OSEL_EXT: ok = ext_ok;
      cgs_pkg::OSEL_RSVD: ok = 1'b0;
    endcase
    return ok;
  endfunction

  cgs_axil u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .reg_wr(reg_wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // pins from the analog side pass four flops: three stages and the registered output
  cgs_sync3 #(.W(1), .RST(1'b0)) u_band (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(loop_in_band),
    .q(band_s)
  );

  cgs_sync3 #(.W(1), .RST(1'b0)) u_extok (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(ext_ref_ok),
    .q(ext_ok_s)
  );

  // reference source status comes back through the reference domain crossing
  cgs_sync3 #(.W(1), .RST(cgs_pkg::CTRL_RST[cgs_pkg::CTRL_REFSEL])) u_refst (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(s_q.ctrl[cgs_pkg::CTRL_REFSEL]),
    .q(ref_status)
  );

  // accepted output select also crosses before it shows in status
  cgs_sync3 #(.W(2), .RST(2'b00)) u_oselst (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(s_q.osel_acc),
    .q(osel_status_raw)
  );

  assign osel_status = cgs_pkg::cgs_osel_t'(osel_status_raw);
  assign osel_req = cgs_pkg::cgs_osel_t'(s_q.ctrl[cgs_pkg::CTRL_OSEL_LO +: 2]);

  // write decode
  assign wr_ctrl = reg_wr.en && (reg_wr.addr == cgs_pkg::OFF_CTRL);
  assign wr_trim = reg_wr.en && (reg_wr.addr == cgs_pkg::OFF_TRIM);
  assign wr_status = reg_wr.en && (reg_wr.addr == cgs_pkg::OFF_STATUS);

  // the loop is off in the low-power bypass modes, which stops lock detection
  assign loop_on = !(s_q.cfg[cgs_pkg::CFG_LOW_POWER] && (osel_status != cgs_pkg::OSEL_LOOP));
  assign loop_enable = loop_on;

  // trim only moves the loop when the internal reference feeds it
  assign trim_sens = ref_status && ((osel_status == cgs_pkg::OSEL_LOOP) || (osel_status == cgs_pkg::OSEL_INT));

  // reference, divider or relevant trim change restarts acquisition
  always_comb begin
    cfg_chg = 1'b0;
    if (wr_ctrl && (reg_wr.data[cgs_pkg::CTRL_REFSEL] != s_q.ctrl[cgs_pkg::CTRL_REFSEL])) begin
      cfg_chg = 1'b1;
    end
    if (wr_ctrl && (reg_wr.data[cgs_pkg::CTRL_DIV_LO +: 3] != s_q.ctrl[cgs_pkg::CTRL_DIV_LO +: 3])) begin
      cfg_chg = 1'b1;
    end
    if (wr_trim && trim_sens && (reg_wr.data != s_q.trim)) begin
      cfg_chg = 1'b1;
    end
  end

  // loss of lock: previously locked, loop running, frequency out of band
  assign lose_evt = s_q.locked && loop_on && !band_s;
  // write-one clear; a zero in that bit leaves the flag alone
  assign lost_clr = wr_status && reg_wr.data[cgs_pkg::STAT_LOST] && s_q.lost;

  // next state of the register file, lock tracker and output selector
  always_comb begin
    s_d = s_q;
    if (wr_ctrl) begin
      s_d.ctrl = reg_wr.data;
    end
    if (wr_trim) begin
      s_d.trim = reg_wr.data;
    end
    if (reg_wr.en && (reg_wr.addr == cgs_pkg::OFF_CFG)) begin
      s_d.cfg = reg_wr.data;
    end
    // set wins over clear so a loss in the clearing cycle is kept
    if (lost_clr) begin
      s_d.lost = 1'b0;
    end
    if (lose_evt) begin
      s_d.lost = 1'b1;
    end
    // lock is dropped by the loop stopping, stop entry, a change or leaving the band
    if (!loop_on || stop_entry || cfg_chg || !band_s) begin
      s_d.locked = 1'b0;
      s_d.acq_cnt = '0;
    end else if (!s_q.locked) begin
      if (s_q.acq_cnt == ACQ_LAST) begin
        s_d.locked = 1'b1;
      end else begin
        s_d.acq_cnt = s_q.acq_cnt + ACQ_W'(1);
      end
    end
    // a new selection is taken only if that clock is available
    if ((osel_req != s_q.osel_acc) && osel_avail(osel_req, ext_ok_s)) begin
      s_d.osel_acc = osel_req;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.ctrl <= cgs_pkg::CTRL_RST;
      s_q.trim <= cgs_pkg::TRIM_RST;
      s_q.cfg <= cgs_pkg::CFG_RST;
      s_q.osel_acc <= cgs_pkg::OSEL_LOOP;
      s_q.locked <= 1'b0;
      s_q.lost <= 1'b0;
      s_q.acq_cnt <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // status word; reserved bits are constant zero
  always_comb begin
    status_val = 8'h00;
    status_val[cgs_pkg::STAT_LOST] = s_q.lost;
    status_val[cgs_pkg::STAT_LOCK] = s_q.locked;
    status_val[cgs_pkg::STAT_REFSRC] = ref_status;
    status_val[cgs_pkg::STAT_OSEL_LO +: 2] = osel_status;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    unique case (rd_addr)
      cgs_pkg::OFF_CTRL: rd_data = s_q.ctrl;
      cgs_pkg::OFF_STATUS: rd_data = status_val;
      cgs_pkg::OFF_TRIM: rd_data = s_q.trim;
      cgs_pkg::OFF_CFG: rd_data = s_q.cfg;
      default: rd_data = 8'h00;
    endcase
  end

  // request only while the flag is set and enabled
  assign irq = s_q.lost && s_q.cfg[cgs_pkg::CFG_IRQ_EN];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_lost_set;
    lose_evt |=> s_q.lost ##1 (s_q.lost || $past(lost_clr));
  endproperty
  a_lost_set: assert property (p_lost_set) else $error("loss of lock did not set flag");

  property p_irq;
    s_q.lost && s_q.cfg[cgs_pkg::CFG_IRQ_EN] && !lost_clr
      |=> irq || $past(reg_wr.en && (reg_wr.addr == cgs_pkg::OFF_CFG));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing for enabled flag");

  property p_no_irq;
    !s_q.cfg[cgs_pkg::CFG_IRQ_EN] || !s_q.lost |-> !irq;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt without enable and flag");

  property p_w1c;
    lost_clr && !lose_evt |=> !s_q.lost;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_sticky;
    s_q.lost && !lost_clr |=> s_q.lost;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_loop_off;
    !loop_on |=> !s_q.locked;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("locked while loop off");

  property p_chg;
    cfg_chg |=> !s_q.locked;
  endproperty
  a_chg: assert property (p_chg) else $error("lock kept after change");

  property p_stop;
    stop_entry |=> !s_q.locked ##1 !s_q.locked;
  endproperty
  a_stop: assert property (p_stop) else $error("lock kept after stop entry");

  property p_ref_lag;
    $changed(s_q.ctrl[cgs_pkg::CTRL_REFSEL]) ##1 $stable(s_q.ctrl[cgs_pkg::CTRL_REFSEL]) [*4]
      |-> ref_status == s_q.ctrl[cgs_pkg::CTRL_REFSEL];
  endproperty
  a_ref_lag: assert property (p_ref_lag) else $error("source status did not follow select");

  property p_osel_lag;
    $changed(s_q.osel_acc) |-> $stable(osel_status) ##1 $stable(osel_status);
  endproperty
  a_osel_lag: assert property (p_osel_lag) else $error("output status changed without lag");

  property p_keep_prev;
    (osel_req == cgs_pkg::OSEL_EXT) && !ext_ok_s |=> s_q.osel_acc == $past(s_q.osel_acc);
  endproperty
  a_keep_prev: assert property (p_keep_prev) else $error("unavailable clock was selected");

  property p_lp_off;
    s_q.cfg[cgs_pkg::CFG_LOW_POWER] && (osel_status != cgs_pkg::OSEL_LOOP) && !s_q.lost |=> !s_q.lost;
  endproperty
  a_lp_off: assert property (p_lp_off) else $error("lock detection active in low power");

  c_lost: cover property ($rose(s_q.lost));
  c_lock: cover property ($rose(s_q.locked));
  c_ext: cover property (osel_status == cgs_pkg::OSEL_EXT);
  c_irq: cover property ($rose(irq));

endmodule

/* File: cgs_status_top_test.sv */
`timescale 1ns/1ps
module cgs_status_top_test;
  // short lock count keeps the run brief; settle covers sync flops plus acquisition
  localparam int LOCK_N = 8;
  localparam int SETTLE = LOCK_N + 12;
  localparam logic [7:0] A_CT = cgs_pkg::OFF_CTRL;
  localparam logic [7:0] A_ST = cgs_pkg::OFF_STATUS;
  localparam logic [7:0] A_TR = cgs_pkg::OFF_TRIM;
  localparam logic [7:0] A_CF = cgs_pkg::OFF_CFG;
  localparam logic [1:0] OK = cgs_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = cgs_pkg::RESP_SLVERR;
  logic aclk;
  logic aresetn;
  cgs_pkg::cgs_axi_req_t axi_req;
  cgs_pkg::cgs_axi_rsp_t axi_rsp;
  logic loop_in_band;
  logic ext_ref_ok;
  logic stop_entry;
  logic loop_enable;
  logic irq;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h0000005B;
  logic [2:0] cur_div;
  logic [7:0] cur_trim;
  logic [7:0] nv;

  cgs_status_top #(.LOCK_ACQ_CYCLES(LOCK_N)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .loop_in_band(loop_in_band), .ext_ref_ok(ext_ref_ok), .stop_entry(stop_entry),
    .loop_enable(loop_enable), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // hang guard: a few thousand cycles is well past the longest sequence
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // expected status byte; reserved bits 5 and 1:0 always zero
  function automatic logic [31:0] st(input logic lost, input logic lock, input logic rf, input logic [1:0] os);
    return {24'h000000, lost, lock, 1'b0, rf, os, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // handshakes are judged at the falling edge, where nothing moves until the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    logic haw;
    logic hw;
    logic b;
    logic [1:0] rs;
    b = 1'b0;
    axi_req.awaddr <= a;
    axi_req.wdata <= {24'h000000, d};
    axi_req.wstrb <= s;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    while (b !== 1'b1) begin
      @(negedge aclk);
      haw = axi_req.awvalid & axi_rsp.awready;
      hw = axi_req.wvalid & axi_rsp.wready;
      b = axi_rsp.bvalid;
      rs = axi_rsp.bresp;
      @(posedge aclk);
      if (haw === 1'b1) axi_req.awvalid <= 1'b0;
      if (hw === 1'b1) axi_req.wvalid <= 1'b0;
    end
    axi_req.bready <= 1'b0;
    chk("bresp", {30'h0, rs}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic har;
    logic r;
    logic [31:0] dt;
    logic [1:0] rs;
    r = 1'b0;
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    while (r !== 1'b1) begin
      @(negedge aclk);
      har = axi_req.arvalid & axi_rsp.arready;
      r = axi_rsp.rvalid;
      dt = axi_rsp.rdata;
      rs = axi_rsp.rresp;
      @(posedge aclk);
      if (har === 1'b1) axi_req.arvalid <= 1'b0;
    end
    axi_req.rready <= 1'b0;
    chk(nm, dt, exp);
    chk("rresp", {30'h0, rs}, {30'h0, er});
    @(posedge aclk);
  endtask

  initial begin
    axi_req <= '0;
    aresetn <= 1'b0;
    loop_in_band <= 1'b0;
    ext_ref_ok <= 1'b0;
    stop_entry <= 1'b0;
    cur_div = 3'h0;
    cur_trim = 8'h80;
    tick(10);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset state and the unmapped slot
    rc("status", A_ST, st(0, 0, 1, 2'b00), OK);
    rc("ctrl", A_CT, 32'h00000004, OK);
    rc("trim", A_TR, 32'h00000080, OK);
    rc("cfg", A_CF, 32'h00000000, OK);
    chk("loop_enable", {31'h0, loop_enable}, 32'h00000001);
    rc("unmapped", 8'h10, 32'h00000000, ERR);
    wr(8'h14, 8'hFF, 4'hF, ERR);
    // acquire, lose, relock: the flag sticks and only a one clears it
    loop_in_band <= 1'b1;
    tick(SETTLE);
    rc("status", A_ST, st(0, 1, 1, 2'b00), OK);
    loop_in_band <= 1'b0;
    tick(12);
    rc("status", A_ST, st(1, 0, 1, 2'b00), OK);
    chk("irq", {31'h0, irq}, 32'h00000000);
    wr(A_CF, 8'h80, 4'hF, OK);
    chk("irq", {31'h0, irq}, 32'h00000001);
    loop_in_band <= 1'b1;
    tick(SETTLE);
    rc("status", A_ST, st(1, 1, 1, 2'b00), OK);
    wr(A_ST, 8'h7F, 4'hF, OK);
    rc("status", A_ST, st(1, 1, 1, 2'b00), OK);
    wr(A_ST, 8'h80, 4'hF, OK);
    rc("status", A_ST, st(0, 1, 1, 2'b00), OK);
    chk("irq", {31'h0, irq}, 32'h00000000);
    // a write without its low byte strobe leaves the trim alone
    wr(A_TR, 8'h7F, 4'hE, OK);
    rc("trim", A_TR, {24'h0, cur_trim}, OK);
    // random divider and trim changes and stop entries all drop lock
    for (int i = 0; i < 6; i++) begin
      nv = 8'(rnd());
      if (i % 3 == 0) begin
        if (nv[2:0] == cur_div) nv[2:0] = cur_div ^ 3'h1;
        cur_div = nv[2:0];
        wr(A_CT, {2'b00, cur_div, 3'b100}, 4'hF, OK);
      end else if (i % 3 == 1) begin
        if (nv == cur_trim) nv = cur_trim ^ 8'h01;
        cur_trim = nv;
        wr(A_TR, cur_trim, 4'hF, OK);
      end else begin
        stop_entry <= 1'b1;
        @(posedge aclk);
        stop_entry <= 1'b0;
      end
      rc("status", A_ST, st(0, 0, 1, 2'b00), OK);
      tick(SETTLE);
      rc("status", A_ST, st(0, 1, 1, 2'b00), OK);
    end
    // reference select: lock drops at once, source status lags
    wr(A_CT, 8'h00, 4'hF, OK);
    rc("status", A_ST, st(0, 0, 1, 2'b00), OK);
    tick(SETTLE);
    rc("status", A_ST, st(0, 1, 0, 2'b00), OK);
    wr(A_CT, 8'h04, 4'hF, OK);
    tick(SETTLE);
    // output select: lag, encodings, unavailable and reserved choices refused
    wr(A_CT, 8'h44, 4'hF, OK);
    rc("status", A_ST, st(0, 1, 1, 2'b00), OK);
    tick(10);
    rc("status", A_ST, st(0, 1, 1, 2'b01), OK);
    wr(A_CT, 8'h84, 4'hF, OK);
    tick(10);
    rc("status", A_ST, st(0, 1, 1, 2'b01), OK);
    wr(A_CT, 8'hC4, 4'hF, OK);
    tick(10);
    rc("status", A_ST, st(0, 1, 1, 2'b01), OK);
    ext_ref_ok <= 1'b1;
    tick(10);
    wr(A_CT, 8'h80, 4'hF, OK);
    tick(SETTLE);
    rc("status", A_ST, st(0, 1, 0, 2'b10), OK);
    wr(A_CT, 8'h44, 4'hF, OK);
    tick(SETTLE);
    rc("status", A_ST, st(0, 1, 1, 2'b01), OK);
    // low-power bypass: loop off, no lock and no loss flag
    wr(A_CF, 8'h81, 4'hF, OK);
    chk("loop_enable", {31'h0, loop_enable}, 32'h00000000);
    tick(10);
    rc("status", A_ST, st(0, 0, 1, 2'b01), OK);
    loop_in_band <= 1'b0;
    tick(12);
    rc("status", A_ST, st(0, 0, 1, 2'b01), OK);
    chk("irq", {31'h0, irq}, 32'h00000000);
    end_sim();
  end
endmodule

/* File: cgs_sync3.sv */
`timescale 1ns/1ps
// three-stage synchroniser with a registered output flop; output moves once the second and third stages agree
module cgs_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } cgs_sync_st_t;

  cgs_sync_st_t s_q;
  cgs_sync_st_t s_d;

  // stage one feeds stage two only, so no logic sees a metastable value
  always_comb begin
    s_d = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.q = s_q.s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= {4{RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.q;

endmodule
